// file: core/lkd_top.sv
`timescale 1ns/100ps
module lkd_top #(
   parameter int OSC_DIV = 4
) (
   input logic CORE_CLK,
   input logic RST,
   input logic CHIP_EN,
   input logic SERIAL_CLOCK_IN,
   input logic SERIAL_DATA_IN,
   input logic [lkd_pkg::NUM_RET-1:0] RETURN_INPUTS,
   output logic DATA_OUT,
   output logic DATA_OUT_OE_N,
   output logic [lkd_pkg::NUM_SCAN-1:0] SCAN_LINES,
   output logic [lkd_pkg::NUM_SEG-1:0] SEG_OUT,
   output logic [lkd_pkg::NUM_COM-1:0] COMMON_LINES,
   output logic BIAS_HALF,
   output logic SEGMENTS_BLANK,
   output logic OSC_RUN,
   output logic SLEEP_MODE
);
   import lkd_pkg::*;

   localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;

   // ==========================================================
   // decode functions
   function automatic logic [2:0] port_count(input lkd_ctrl_s c);
      if (c.port_sel_a) begin
         port_count = 3'h4;
      end else begin
         port_count = {1'b0, c.port_sel_b, c.port_sel_c};
      end
   endfunction

   function automatic logic [5:0] standby_lines(input lkd_ctrl_s c);
      unique case ({c.sleep_sel_a, c.sleep_sel_b})
         2'b01: standby_lines = SCAN_L6;
         2'b10: standby_lines = SCAN_L56;
         default: standby_lines = SCAN_ALL;
      endcase
   endfunction

   // which scan lines really exist as scan outputs
   function automatic logic [5:0] scan_use(input lkd_ctrl_s c);
      scan_use = SCAN_ALL;
      if (c.scan_pin_sel_a) begin
         scan_use = SCAN_ALL & ~(SCAN_ONE | (SCAN_ONE << 1));
      end else if (c.scan_pin_sel_b) begin
         scan_use = SCAN_ALL & ~SCAN_ONE;
      end
   endfunction

   function automatic logic [29:0] key_use(input lkd_ctrl_s c);
      key_use = ~30'h0;
      if (c.scan_pin_sel_a) begin
         key_use = ~KEY_LINE12;
      end else if (c.scan_pin_sel_b) begin
         key_use = ~KEY_LINE1;
      end
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [SYNC_W-1:0] pin_raw, pin_st;
   lkd_ser_s ser, ser_prev_r;
   logic [NUM_RET-1:0] ret;

   assign pin_raw = {RETURN_INPUTS, CHIP_EN, SERIAL_CLOCK_IN, SERIAL_DATA_IN};

   lkd_sync #(.W(SYNC_W)) u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .d_in(pin_raw),
      .q_out(pin_st)
   );

   assign ser = lkd_ser_s'(pin_st[2:0]);
   assign ret = pin_st[SYNC_W-1:3];

   // ==========================================================
   // serial interface
   logic [ADDR_W-1:0] addr_sr_r, addr_sr_nxt;
   logic wr_act_r, wr_act_nxt, rd_act_r, rd_act_nxt;
   logic [6:0] bit_cnt_r, bit_cnt_nxt;
   logic [NUM_DISP+NUM_CTRL-1:0] wr_sr_r, wr_sr_nxt;
   logic [NUM_KEYS:0] rd_sr_r, rd_sr_nxt;
   logic [NUM_DISP-1:0] disp_r, disp_nxt;
   lkd_ctrl_s ctrl_r, ctrl_nxt;
   logic ce_rise, ce_fall, clk_rise;
   logic rd_load, rd_done, wr_done;
   logic [NUM_KEYS-1:0] key_r, key_nxt;
   logic sa_r, sa_nxt, sleep;

   assign ce_rise = ser.ce & ~ser_prev_r.ce;
   assign ce_fall = ~ser.ce & ser_prev_r.ce;
   assign clk_rise = ser.clk & ~ser_prev_r.clk;
   assign sleep = ctrl_r.sleep_sel_a | ctrl_r.sleep_sel_b;

   // address shifts in with enable low; payload with enable high
   always_comb begin
      addr_sr_nxt = addr_sr_r;
      wr_act_nxt = wr_act_r;
      rd_act_nxt = rd_act_r;
      bit_cnt_nxt = bit_cnt_r;
      wr_sr_nxt = wr_sr_r;
      rd_sr_nxt = rd_sr_r;
      disp_nxt = disp_r;
      ctrl_nxt = ctrl_r;
      rd_load = 1'b0;
      rd_done = 1'b0;
      wr_done = 1'b0;
      if (ce_rise) begin
         wr_act_nxt = (addr_sr_r == ADDR_DISP_WRITE);
         rd_act_nxt = (addr_sr_r == ADDR_KEY_READ);
         bit_cnt_nxt = '0;
         if (addr_sr_r == ADDR_KEY_READ) begin
            rd_load = 1'b1;
            rd_sr_nxt = {sa_r, key_r & key_use(ctrl_r)};
         end
      end else if (ce_fall) begin
         wr_act_nxt = 1'b0;
         rd_act_nxt = 1'b0;
         // a short or long frame is dropped whole, so no half-updated mode
         if (wr_act_r && bit_cnt_r == WR_BITS) begin
            wr_done = 1'b1;
            disp_nxt = wr_sr_r[NUM_DISP-1:0];
            ctrl_nxt = lkd_ctrl_s'(wr_sr_r[NUM_DISP+NUM_CTRL-1:NUM_DISP]);
         end
         rd_done = rd_act_r && (bit_cnt_r >= RD_BITS);
      end else if (clk_rise) begin
         if (!ser.ce) begin
            addr_sr_nxt = {ser.din, addr_sr_r[ADDR_W-1:1]};
         end else begin
            if (bit_cnt_r != CNT_MAX) begin
               bit_cnt_nxt = bit_cnt_r + 7'h01;
            end
            if (wr_act_r) begin
               wr_sr_nxt = {ser.din, wr_sr_r[NUM_DISP+NUM_CTRL-1:1]};
            end
            if (rd_act_r) begin
               rd_sr_nxt = {1'b0, rd_sr_r[NUM_KEYS:1]};
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ser_prev_r <= '0;
         addr_sr_r <= '0;
         wr_act_r <= 1'b0;
         rd_act_r <= 1'b0;
         bit_cnt_r <= '0;
         wr_sr_r <= '0;
         rd_sr_r <= '0;
         disp_r <= '0;
         ctrl_r <= CTRL_RST;
      end else begin
         ser_prev_r <= ser;
         addr_sr_r <= addr_sr_nxt;
         wr_act_r <= wr_act_nxt;
         rd_act_r <= rd_act_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         wr_sr_r <= wr_sr_nxt;
         rd_sr_r <= rd_sr_nxt;
         disp_r <= disp_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // ==========================================================
   // oscillator stand-in and common frame timing
   lkd_scan_e ks_r, ks_nxt;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic [8:0] com_cnt_r, com_cnt_nxt;
   logic [1:0] com_idx_r, com_idx_nxt;
   logic osc_run, tick;

   // stopped in sleep until a key press starts a scan
   assign osc_run = ~sleep | (ks_r != KS_IDLE);
   assign tick = osc_run && (div_r == DIV_W'(OSC_DIV - 1));

   always_comb begin
      div_nxt = '0;
      com_cnt_nxt = com_cnt_r;
      com_idx_nxt = com_idx_r;
      if (osc_run && !tick) begin
         div_nxt = div_r + DIV_W'(1);
      end
      if (tick) begin
         // three slots of 128 periods make one 384-period frame
         if (com_cnt_r == COM_SLOT_T - 9'h001) begin
            com_cnt_nxt = '0;
            com_idx_nxt = (com_idx_r == LAST_COM) ? 2'h0 : com_idx_r + 2'h1;
         end else begin
            com_cnt_nxt = com_cnt_r + 9'h001;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         div_r <= '0;
         com_cnt_r <= '0;
         com_idx_r <= '0;
      end else begin
         div_r <= div_nxt;
         com_cnt_r <= com_cnt_nxt;
         com_idx_r <= com_idx_nxt;
      end
   end

   // ==========================================================
   // key scanner: two passes, compare, request
   logic [9:0] kt_r, kt_nxt, slot_r, slot_nxt;
   logic [2:0] line_r, line_nxt;
   logic [NUM_KEYS-1:0] kd_a_r, kd_a_nxt, kd_b_r, kd_b_nxt;
   logic req_r, req_nxt;

   always_comb begin
      ks_nxt = ks_r;
      kt_nxt = kt_r;
      slot_nxt = slot_r;
      line_nxt = line_r;
      kd_a_nxt = kd_a_r;
      kd_b_nxt = kd_b_r;
      key_nxt = key_r;
      sa_nxt = sa_r;
      req_nxt = req_r;
      unique case (ks_r)
         KS_IDLE: begin
            // only a key on a line driven high can raise a return input
            if (|ret) begin
               ks_nxt = KS_SCAN;
               kt_nxt = '0;
               slot_nxt = '0;
               line_nxt = '0;
               kd_a_nxt = '0;
               kd_b_nxt = '0;
            end
         end
         KS_SCAN: begin
            if (tick) begin
               kt_nxt = kt_r + 10'h001;
               if (kt_r < SCAN_SPAN_T) begin
                  slot_nxt = slot_r + 10'h001;
                  if (slot_r == SCAN_LINE_T - 10'h001) begin
                     slot_nxt = '0;
                     line_nxt = (line_r == LAST_LINE) ? 3'h0 : line_r + 3'h1;
                     if (kt_r < SCAN_PERIOD_T) begin
                        kd_a_nxt[line_r*NUM_RET +: NUM_RET] = ret;
                     end else begin
                        kd_b_nxt[line_r*NUM_RET +: NUM_RET] = ret;
                     end
                  end
               end
               if (kt_r == KEY_REQ_T - 10'h001) begin
                  if (kd_a_r == kd_b_r && |(kd_b_r & key_use(ctrl_r))) begin
                     key_nxt = kd_b_r & key_use(ctrl_r);
                     sa_nxt = sleep;
                     req_nxt = 1'b1;
                     ks_nxt = KS_WAIT;
                  end else if (|kd_b_r) begin
                     // unstable data, or only masked keys, while still held: scan again
                     kt_nxt = '0;
                     slot_nxt = '0;
                     line_nxt = '0;
                     kd_a_nxt = '0;
                     kd_b_nxt = '0;
                  end else begin
                     ks_nxt = KS_IDLE;
                  end
               end
            end
         end
         KS_WAIT: begin
            if (rd_done) begin
               req_nxt = 1'b0;
               ks_nxt = KS_SCAN;
               kt_nxt = '0;
               slot_nxt = '0;
               line_nxt = '0;
               kd_a_nxt = '0;
               kd_b_nxt = '0;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ks_r <= KS_IDLE;
         kt_r <= '0;
         slot_r <= '0;
         line_r <= '0;
         kd_a_r <= '0;
         kd_b_r <= '0;
         key_r <= '0;
         sa_r <= 1'b0;
         req_r <= 1'b0;
      end else begin
         ks_r <= ks_nxt;
         kt_r <= kt_nxt;
         slot_r <= slot_nxt;
         line_r <= line_nxt;
         kd_a_r <= kd_a_nxt;
         kd_b_r <= kd_b_nxt;
         key_r <= key_nxt;
         sa_r <= sa_nxt;
         req_r <= req_nxt;
      end
   end

   // ==========================================================
   // pin outputs, all registered
   logic [NUM_SCAN-1:0] scan_nxt;
   logic [NUM_SEG-1:0] seg_nxt;
   logic [NUM_COM-1:0] com_nxt;
   logic pull_nxt;
   logic [NUM_SCAN-1:0] lines_used;

   // a select straight on a function result is not portable, so decode once here
   assign lines_used = scan_use(ctrl_r);

   always_comb begin
      scan_nxt = standby_lines(ctrl_r) & scan_use(ctrl_r);
      if (ks_r == KS_SCAN) begin
         scan_nxt = '0;
         if (kt_r < SCAN_SPAN_T) begin
            scan_nxt = (SCAN_ONE << line_r) & scan_use(ctrl_r);
         end
      end
      com_nxt = '0;
      if (!sleep) begin
         com_nxt[com_idx_r] = 1'b1;
      end
      for (int n = 0; n < NUM_SEG; n++) begin
         // segment off shown as an idle pin; waveform shaping is analog
         seg_nxt[n] = disp_r[n*NUM_COM + int'(com_idx_r)] & ~sleep &
                      ~ctrl_r.segments_blank;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (3'(p) < port_count(ctrl_r)) begin
            seg_nxt[p] = disp_r[p*NUM_COM];
         end
      end
      if (lines_used[0]) begin
         seg_nxt[NUM_SEG-2] = scan_nxt[0];
      end
      if (lines_used[1]) begin
         seg_nxt[NUM_SEG-1] = scan_nxt[1];
      end
      // request pulls low only outside a transfer
      pull_nxt = rd_act_r ? ~rd_sr_r[0] : (req_r & ~ser.ce);
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         SCAN_LINES <= '0;
         SEG_OUT <= '0;
         COMMON_LINES <= '0;
         BIAS_HALF <= 1'b0;
         SEGMENTS_BLANK <= 1'b0;
         OSC_RUN <= 1'b0;
         SLEEP_MODE <= 1'b0;
         DATA_OUT <= 1'b0;
         DATA_OUT_OE_N <= 1'b1;
      end else begin
         SCAN_LINES <= scan_nxt;
         SEG_OUT <= seg_nxt;
         COMMON_LINES <= com_nxt;
         BIAS_HALF <= ctrl_r.bias_select;
         SEGMENTS_BLANK <= ctrl_r.segments_blank;
         OSC_RUN <= osc_run;
         SLEEP_MODE <= sleep;
         DATA_OUT <= 1'b0;
         DATA_OUT_OE_N <= ~pull_nxt;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   chk_sleep_outputs_low: assert property (
      sleep && ks_r == KS_IDLE |=> !OSC_RUN && COMMON_LINES == '0 && !SEG_OUT[NUM_SEG/2])
      else $error("sleep did not stop outputs");
   chk_standby_lines: assert property (
      ks_r == KS_IDLE && $stable(ctrl_r)
      |=> SCAN_LINES == $past(standby_lines(ctrl_r) & scan_use(ctrl_r)))
      else $error("standby scan lines wrong");
   chk_seg_pin_mode: assert property (
      ctrl_r.scan_pin_sel_a |=> SCAN_LINES[1:0] == 2'b00)
      else $error("shared pin still scanning");
   chk_port_level: assert property (
      port_count(ctrl_r) != 3'h0 |=> SEG_OUT[0] == $past(disp_r[0]))
      else $error("port pin not following its bit");
   chk_blank_mid: assert property (
      ctrl_r.segments_blank |=> !SEG_OUT[NUM_SEG/2])
      else $error("blanked segment lit");
   chk_seg_map: assert property (
      !sleep && !ctrl_r.segments_blank
      |=> SEG_OUT[NUM_SEG/2] == $past(disp_r[(NUM_SEG/2)*NUM_COM + int'(com_idx_r)]))
      else $error("segment map wrong");
   chk_key_mask: assert property (
      rd_load && ctrl_r.scan_pin_sel_a |=> rd_sr_r[2*NUM_RET-1:0] == '0)
      else $error("masked key bits not zero");
   chk_req_timing: assert property (
      $rose(req_r) |-> $past(kt_r) == KEY_REQ_T - 10'h001 && sa_r == $past(sleep))
      else $error("request at wrong time");
   chk_do_ce_high: assert property (
      ser.ce && !rd_act_r |=> DATA_OUT_OE_N)
      else $error("serial output pulled during transfer");
   chk_read_release: assert property (
      rd_done && ks_r == KS_WAIT |=> !req_r && ks_r == KS_SCAN ##2 DATA_OUT_OE_N)
      else $error("request not released after read");
   chk_ctrl_atomic: assert property (
      !wr_done |=> $stable(ctrl_r))
      else $error("control changed outside latch");

   cov_key_request: cover property ($rose(req_r));
   cov_read_done: cover property (rd_done && req_r);
   cov_sleep_wake: cover property (sleep && ks_r == KS_IDLE ##1 ks_r == KS_SCAN);
   cov_write_done: cover property (wr_done);
endmodule

// file: pkg/lkd_pkg.sv
package lkd_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_DISP = 75;
   localparam int NUM_SEG = 25;
   localparam int NUM_COM = 3;
   localparam int NUM_SCAN = 6;
   localparam int NUM_RET = 5;
   localparam int NUM_KEYS = 30;
   localparam int NUM_PORTS = 4;
   localparam int NUM_CTRL = 9;
   localparam int ADDR_W = 8;
   localparam int SYNC_W = 8;

   // ==========================================================
   // serial framing
   localparam logic [7:0] ADDR_KEY_READ = 8'h43;
   localparam logic [7:0] ADDR_DISP_WRITE = 8'h42;
   localparam logic [6:0] WR_BITS = 7'h54;     // 75 display + 9 control
   localparam logic [6:0] RD_BITS = 7'h1F;     // 30 keys + acknowledge
   localparam logic [6:0] CNT_MAX = 7'h7F;

   // ==========================================================
   // timing in oscillator periods
   localparam logic [9:0] KEY_REQ_T = 10'h267;      // 615
   localparam logic [9:0] SCAN_PERIOD_T = 10'h120;  // 288
   localparam logic [9:0] SCAN_SPAN_T = 10'h240;    // two passes
   localparam logic [9:0] SCAN_LINE_T = 10'h030;    // 288 / 6
   localparam logic [8:0] FRAME_T = 9'h180;         // 384
   localparam logic [8:0] COM_SLOT_T = FRAME_T / 9'h003;
   localparam logic [2:0] LAST_LINE = 3'h5;
   localparam logic [1:0] LAST_COM = 2'h2;

   // ==========================================================
   // scan line patterns
   localparam logic [5:0] SCAN_ALL = 6'h3F;
   localparam logic [5:0] SCAN_L6 = 6'h20;
   localparam logic [5:0] SCAN_L56 = 6'h30;
   localparam logic [5:0] SCAN_ONE = 6'h01;
   localparam logic [29:0] KEY_LINE1 = 30'h0000001F;
   localparam logic [29:0] KEY_LINE12 = 30'h000003FF;

   // ==========================================================
   // types
   typedef struct packed {
      logic sleep_sel_a;
      logic sleep_sel_b;
      logic scan_pin_sel_a;
      logic scan_pin_sel_b;
      logic port_sel_a;
      logic port_sel_b;
      logic port_sel_c;
      logic segments_blank;
      logic bias_select;
   } lkd_ctrl_s;

   typedef struct packed {
      logic ce;
      logic clk;
      logic din;
   } lkd_ser_s;

   typedef enum logic [1:0] {KS_IDLE, KS_SCAN, KS_WAIT} lkd_scan_e;

   localparam lkd_ctrl_s CTRL_RST = '0;

endpackage

// file: core/lkd_sync.sv
`timescale 1ns/100ps
module lkd_sync #(
   parameter int W = 1
) (
   input logic clk,
   input logic rst,
   input logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] ff1_r, ff2_r, ff3_r, q_r, q_nxt;

   // ==========================================================
   // three stages; a bit moves only once the last two agree
   always_comb begin
      q_nxt = (ff2_r & ~(ff2_r ^ ff3_r)) | (q_r & (ff2_r ^ ff3_r));
   end

   // first stage feeds only the second, to keep metastability contained
   always_ff @(posedge clk) begin
      if (rst) begin
         ff1_r <= '0;
         ff2_r <= '0;
         ff3_r <= '0;
         q_r <= '0;
      end else begin
         ff1_r <= d_in;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
         q_r <= q_nxt;
      end
   end

   assign q_out = q_r;
endmodule

// file: test/lkd_host_model.sv
`timescale 1ns/100ps
// ==========================================
// host controller on the three-wire serial link
module lkd_host_model (
   input wire logic core_clk,
   input wire logic data_line,
   output logic chip_en,
   output logic ser_clk,
   output logic ser_din
);
   import lkd_pkg::*;
   localparam int HALF = 4; // 80 ns, half of the 160 ns link clock

   // link clock stands low between frames
   initial begin
      chip_en = 1'b0;
      ser_clk = 1'b0;
      ser_din = 1'b0;
   end

   // every pin level is held for half a link period
   task automatic half_wait();
      repeat (HALF) @(negedge core_clk);
   endtask

   // data set up in the low phase, taken by the device on the rise
   task automatic clk_bit(input logic b);
      ser_din = b;
      half_wait();
      ser_clk = 1'b1;
      half_wait();
      ser_clk = 1'b0; // data holds until the next bit sets it up
   endtask

   // address with chip enable low, lsb first, then open the payload
   task automatic send_addr(input logic [7:0] a);
      chip_en = 1'b0;
      for (int i = 0; i < 8; i++) clk_bit(a[i]);
      half_wait();
      chip_en = 1'b1;
      half_wait();
      half_wait();
   endtask

   // chip enable low closes the frame
   task automatic end_frame();
      half_wait();
      chip_en = 1'b0;
      half_wait();
      half_wait();
   endtask

   // display and control write, n payload bits, lsb first
   task automatic write_frame(input logic [83:0] p, input int n);
      send_addr(ADDR_DISP_WRITE);
      for (int i = 0; i < n; i++) clk_bit(p[i]);
      end_frame();
   endtask

   // key read: 30 key bits then the sleep acknowledge
   task automatic read_frame(output logic [30:0] r, output logic ok);
      ok = (data_line === 1'b0); // data read with no request pending is stale
      send_addr(ADDR_KEY_READ);
      for (int i = 0; i < 31; i++) begin
         half_wait();
         r[i] = data_line; // late in the low phase, bit is settled
         ser_clk = 1'b1;
         half_wait();
         ser_clk = 1'b0;
      end
      end_frame();
   endtask
endmodule

// file: test/tb_lkd_top.sv
`timescale 1ns/100ps
module tb_lkd_top;
   import lkd_pkg::*;
   localparam int OSC_DIV = 1; // short oscillator period keeps the run brief
   localparam logic [74:0] DISP = 75'h2A5_3C96_0F1E_2D4B_8779;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic chip_en, ser_clk, ser_din, data_out, data_oe_n, bias_half, seg_blank;
   logic osc_run, sleep_mode, data_line;
   logic [4:0] ret_in = 5'h00;
   logic [4:0] key_col = 5'h00;
   logic [5:0] key_row = 6'h00;
   logic [5:0] scan_lines;
   logic [24:0] seg_out;
   logic [2:0] com_lines;
   int fail_count = 0;
   int checks = 0;

   // ==========================================
   // clock, open-drain line with pull-up, key matrix
   always #10 core_clk = ~core_clk;
   assign data_line = data_oe_n ? 1'b1 : data_out;
   // a closed key ties its return input to its scan line
   always @(negedge core_clk) begin
      ret_in <= (|(scan_lines & key_row)) ? key_col : 5'h00;
   end

   lkd_host_model i_host (.core_clk(core_clk), .data_line(data_line), .chip_en(chip_en),
      .ser_clk(ser_clk), .ser_din(ser_din));

   lkd_top #(.OSC_DIV(OSC_DIV)) i_dut (.CORE_CLK(core_clk), .RST(rst), .CHIP_EN(chip_en),
      .SERIAL_CLOCK_IN(ser_clk), .SERIAL_DATA_IN(ser_din), .RETURN_INPUTS(ret_in),
      .DATA_OUT(data_out), .DATA_OUT_OE_N(data_oe_n), .SCAN_LINES(scan_lines),
      .SEG_OUT(seg_out), .COMMON_LINES(com_lines), .BIAS_HALF(bias_half),
      .SEGMENTS_BLANK(seg_blank), .OSC_RUN(osc_run), .SLEEP_MODE(sleep_mode));

   // ==========================================
   // helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   function automatic lkd_ctrl_s ctl(input logic [1:0] slp, input logic [1:0] scn,
      input logic [2:0] prt, input logic blk, input logic bia);
      return lkd_ctrl_s'({slp, scn, prt, blk, bia});
   endfunction

   // full write, then room for the latch and the output register
   task automatic wr(input lkd_ctrl_s c);
      i_host.write_frame({c, DISP}, 84);
      repeat (12) @(negedge core_clk);
   endtask

   task automatic wait_req(input int n);
      for (int k = 0; k < n && data_line !== 1'b0; k++) @(negedge core_clk);
      check("request", data_line, 1'b0);
   endtask

   // ==========================================
   // scenarios
   task automatic t_display();
      logic [24:0] exp;
      wr(ctl(2'h0, 2'h2, 3'h0, 1'b0, 1'b1));
      check("bias", {seg_blank, bias_half}, 2'h1);
      for (int c = 0; c < 3; c++) begin
         for (int k = 0; k < 1000 && com_lines !== 3'h1 << c; k++) @(negedge core_clk);
         @(negedge core_clk);
         for (int n = 0; n < 25; n++) exp[n] = DISP[3 * n + c];
         check("segments", seg_out, exp);
      end
      wr(ctl(2'h0, 2'h2, 3'h0, 1'b1, 1'b0));
      check("blank", {seg_blank, bias_half, seg_out}, 27'h4000000);
   endtask

   // frame length measured rise to rise of the first common
   task automatic t_frame();
      int k;
      k = 0;
      while (com_lines[0] === 1'b1) @(negedge core_clk);
      while (com_lines[0] !== 1'b1) @(negedge core_clk);
      do begin
         @(negedge core_clk);
         k++;
      end while (com_lines[0] === 1'b1);
      while (com_lines[0] !== 1'b1) begin
         @(negedge core_clk);
         k++;
      end
      check("frame", k, 384 * OSC_DIV);
   endtask

   // every sleep and scan-pin code and port codes 0 to 4 from one table walk
   task automatic t_ports();
      logic [24:0] m;
      logic [5:0] sc;
      for (int i = 0; i < 5; i++) begin
         wr(ctl(i[1:0], i[1:0], i[2:0], 1'b0, 1'b0));
         sc = (i[1:0] == 2'h1) ? 6'h20 : (i[1:0] == 2'h2) ? 6'h30 : 6'h3F;
         sc = sc & ((i[1:0] == 2'h0) ? 6'h3F : (i[1:0] == 2'h1) ? 6'h3E : 6'h3C);
         check("scan", scan_lines, sc);
         check("mode", {sleep_mode, osc_run}, (i[1:0] != 2'h0) ? 2'h2 : 2'h1);
         m = 25'h0;
         for (int j = 0; j < i; j++) m[j] = DISP[3 * j];
         if (i[1:0] != 2'h0) check("sleep outs", {com_lines, seg_out[22:0]}, m[22:0]);
         for (int j = 0; j < i; j++) check("port", seg_out[j], DISP[3 * j]);
      end
      // one bit short: the whole word is dropped
      i_host.write_frame({ctl(2'h3, 2'h0, 3'h0, 1'b0, 1'b1), DISP}, 83);
      repeat (12) @(negedge core_clk);
      check("short write", {sleep_mode, bias_half}, 2'h0);
   endtask

   task automatic t_key_normal();
      logic [30:0] r;
      logic v;
      wr(ctl(2'h0, 2'h0, 3'h0, 1'b0, 1'b0));
      key_row = 6'h08;
      key_col = 5'h04;
      repeat (600 * OSC_DIV) @(negedge core_clk);
      check("early request", data_line, 1'b1);
      wait_req(100 * OSC_DIV);
      key_row = 6'h00;
      i_host.read_frame(r, v);
      check("valid", v, 1'b1);
      check("keys", r, 31'h1 << 17);
      repeat (12) @(negedge core_clk);
      check("released", data_line, 1'b1);
   endtask

   // press in sleep, then return to normal while the request waits
   task automatic t_key_sleep();
      logic [30:0] r;
      logic v;
      wr(ctl(2'h3, 2'h2, 3'h0, 1'b0, 1'b0));
      check("osc stopped", osc_run, 1'b0);
      key_row = 6'h20;
      key_col = 5'h10;
      repeat (20) @(negedge core_clk);
      check("osc restart", osc_run, 1'b1);
      wait_req(800 * OSC_DIV);
      wr(ctl(2'h0, 2'h2, 3'h0, 1'b0, 1'b0));
      check("mode pending", {sleep_mode, data_line}, 2'h0);
      key_row = 6'h00;
      i_host.read_frame(r, v);
      check("sleep keys", r, 31'h60000000);
      check("sleep valid", v, 1'b1);
   endtask

   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      repeat (10) @(negedge core_clk);
      check("reset", {data_line, sleep_mode, bias_half, scan_lines}, 9'h13F);
      t_display();
      t_frame();
      t_ports();
      t_key_normal();
      t_key_sleep();
      summarize();
   end

   // a hang ends the run as a failure
   initial begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      summarize();
   end
endmodule
